/* clk_ctrl_defs.svh */
// Offsets, field positions, reset values and timing for the control bank
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_PWR          12'hA00
`define IDX_LOOP         12'hA01
`define IDX_CAL          12'hA02
`define IDX_STAT         12'hA0F
`define ADDR_PWR         {`IDX_PWR, 2'b00}
`define ADDR_LOOP        {`IDX_LOOP, 2'b00}
`define ADDR_CAL         {`IDX_CAL, 2'b00}
`define ADDR_STAT        {`IDX_STAT, 2'b00}

// Reset values
`define RST_PWR          8'h00
`define RST_LOOP         8'h00
`define RST_CAL          8'h00

// Power register fields
`define PWR_SOFT_RST     7
`define PWR_SYS_SLEEP    5
`define PWR_REF_SLEEP    4
`define PWR_PHASE_SLEEP  3
`define PWR_DAC_SLEEP    2
`define PWR_DIST_SLEEP   1
`define PWR_FULL_SLEEP   0
`define PWR_WMASK        8'hBF

// Loop register fields
`define LOOP_HOLD        6
`define LOOP_FREE        5
`define LOOP_POL_HI      4
`define LOOP_POL_LO      3
`define LOOP_PREF_HI     1
`define LOOP_PREF_LO     0
`define LOOP_WMASK       8'h7B

// Calibration register fields
`define CAL_SYNC         1
`define CAL_START        0
`define CAL_WMASK        8'h03

// Profile mirror window
`define PROF_HI_PAGE     4'h7
`define PROF_LO_PAGE     4'h6

// Calibration time
`define CLK_FREQ_MHZ     20
`define CAL_TIME_US      2000

`endif

/* clk_ctrl_pkg.sv */
// Types shared by the operational control bank
package clk_ctrl_pkg;

   // Switching policy encodings
   typedef enum logic [1:0] {
      POL_AUTO     = 2'b00,
      POL_FALLBACK = 2'b01,
      POL_HOLDOVER = 2'b10,
      POL_MANUAL   = 2'b11
   } policy_type;

   // Loop operating state
   typedef enum logic [1:0] {
      LOOP_TRACK = 2'b00,
      LOOP_HOLD  = 2'b01,
      LOOP_FREE  = 2'b10
   } loop_state_type;

   // Reference encodings
   typedef enum logic [1:0] {
      REF_A     = 2'b00,
      REF_A_ALT = 2'b01,
      REF_B     = 2'b10,
      REF_B_ALT = 2'b11
   } ref_sel_type;

   // Calibration sequencer
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_RUN  = 2'b01
   } cal_state_type;

endpackage

/* clk_ctrl_regs.sv */
// Operational control register bank with APB slave and loop control
`timescale 1ns/10ps
`include "clk_ctrl_defs.svh"

module clk_ctrl_regs #(
   parameter int unsigned CAL_CYCLES = `CAL_TIME_US * `CLK_FREQ_MHZ
) (
   input  wire logic        pclk,               // System clock, 20 MHz
   input  wire logic        presetn,            // Async reset, active low
   input  wire logic        psel,               // APB select
   input  wire logic        penable,            // APB enable
   input  wire logic        pwrite,             // APB direction
   input  wire logic [13:0] paddr,              // APB byte address
   input  wire logic [31:0] pwdata,             // APB write data
   output logic      [31:0] prdata,             // APB read data
   output logic             pready,             // APB ready
   output logic             pslverr,            // APB error
   input  wire logic [3:0]  ref_valid,          // Per-reference validity
   input  wire logic        auto_ref_found,     // Priority logic has a pick
   input  wire logic [1:0]  auto_ref_sel,       // Priority logic pick
   input  wire logic        sys_pll_enabled,    // System PLL in use
   input  wire logic [11:0] prof_addr,          // Profile register address
   output logic      [11:0] prof_map_addr,      // Mirrored profile address
   output logic             core_reset_hold,    // Internal hardware reset
   output logic             system_clock_sleep, // Input clock and its PLL
   output logic             reference_sleep,    // Reference receivers
   output logic             phase_detector_sleep, // Time-to-digital conv
   output logic             dac_sleep,          // Output DAC
   output logic             distribution_sleep, // Distribution outputs
   output logic             full_sleep,         // Whole device
   output logic      [1:0]  loop_state,         // Track, hold or free run
   output logic      [1:0]  active_ref,         // Active reference
   output logic             freerun_word_sel,   // Use free-run tuning word
   output logic             dist_stall,         // Distribution stalled
   output logic             dist_resync,        // Resync pulse, one cycle
   output logic             cal_busy,           // PLL calibration running
   output logic             system_clock_stall  // Internal clock stalled
);

   logic [7:0]  pwr_ff;
   logic [7:0]  loop_ff;
   logic [7:0]  cal_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [11:0] prof_map_ff;
   logic [1:0]  loop_state_ff;
   logic [1:0]  active_ref_ff;
   logic        sync_prev_ff;
   logic        dist_resync_ff;
   logic [16:0] cal_cnt_ff;
   logic        core_reset_ff;
   logic [5:0]  sleep_ff;
   logic        freerun_sel_ff;
   logic        dist_stall_ff;
   logic        cal_busy_ff;

   clk_ctrl_pkg::cal_state_type  cal_state_ff;
   clk_ctrl_pkg::cal_state_type  nxt_cal_state;
   clk_ctrl_pkg::loop_state_type nxt_loop_state;
   clk_ctrl_pkg::policy_type     policy;
   logic [1:0]  nxt_active_ref;
   logic [1:0]  pref;
   logic        pref_valid;
   logic        access;
   logic        wr_commit;
   logic        hit_pwr;
   logic        hit_loop;
   logic        hit_cal;
   logic        hit_stat;
   logic        hit_any;
   logic        cal_start_ok;
   logic        cal_finish;
   logic        halted;

   localparam logic [16:0] CAL_LOAD = 17'(CAL_CYCLES - 1);

   // Address decode against the byte addresses
   assign hit_pwr  = (paddr == `ADDR_PWR);
   assign hit_loop = (paddr == `ADDR_LOOP);
   assign hit_cal  = (paddr == `ADDR_CAL);
   assign hit_stat = (paddr == `ADDR_STAT);
   assign hit_any  = hit_pwr | hit_loop | hit_cal | hit_stat;

   // One wait state so that read data and ready come from flip-flops
   assign access    = psel & penable;
   assign wr_commit = access & pready_ff & pwrite;

   // Ready pulses in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= access & ~pready_ff;
      end
   end

   // Error on unmapped address or write to the status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else if (access & ~pready_ff) begin
         pslverr_ff <= ~hit_any | (pwrite & hit_stat);
      end else begin
         pslverr_ff <= 1'b0;
      end
   end

   // Read data captured with ready; unmapped reads return zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else if (access & ~pready_ff & ~pwrite) begin
         if (hit_pwr) begin
            prdata_ff <= {24'h000000, pwr_ff};
         end else if (hit_loop) begin
            prdata_ff <= {24'h000000, loop_ff};
         end else if (hit_cal) begin
            prdata_ff <= {24'h000000, cal_ff};
         end else if (hit_stat) begin
            prdata_ff <= {24'h000000, 1'b0, system_clock_stall, cal_busy,
                          dist_stall_ff, loop_state_ff, active_ref_ff};
         end else begin
            prdata_ff <= 32'h00000000;
         end
      end
   end

   // Power control; soft reset leaves this register alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_ff <= `RST_PWR;
      end else if (wr_commit & hit_pwr) begin
         pwr_ff <= pwdata[7:0] & `PWR_WMASK;
      end
   end

   // Loop mode; bit 2 is forced to zero in case software ignores it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_ff <= `RST_LOOP;
      end else if (wr_commit & hit_loop) begin
         loop_ff <= pwdata[7:0] & `LOOP_WMASK;
      end
   end

   // Calibration start may be refused or ended by hardware
   assign cal_start_ok = cal_ff[`CAL_START] & sys_pll_enabled
                         & ~pwr_ff[`PWR_SYS_SLEEP]
                         & ~pwr_ff[`PWR_FULL_SLEEP];
   assign cal_finish   = (cal_state_ff == clk_ctrl_pkg::CAL_RUN)
                         & (cal_cnt_ff == 17'h00000);

   // Software write wins over the hardware clear of the start bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_ff <= `RST_CAL;
      end else if (wr_commit & hit_cal) begin
         cal_ff <= pwdata[7:0] & `CAL_WMASK;
      end else if (cal_finish) begin
         cal_ff[`CAL_START] <= 1'b0;
      end else if ((cal_state_ff == clk_ctrl_pkg::CAL_IDLE)
                   & cal_ff[`CAL_START] & ~cal_start_ok) begin
         cal_ff[`CAL_START] <= 1'b0;
      end
   end

   // Calibration sequencer next state
   always_comb begin
      nxt_cal_state = cal_state_ff;
      case (cal_state_ff)
         clk_ctrl_pkg::CAL_IDLE: begin
            if (cal_start_ok) begin
               nxt_cal_state = clk_ctrl_pkg::CAL_RUN;
            end
         end
         clk_ctrl_pkg::CAL_RUN: begin
            if (cal_cnt_ff == 17'h00000) begin
               nxt_cal_state = clk_ctrl_pkg::CAL_IDLE;
            end
         end
         default: begin
            nxt_cal_state = clk_ctrl_pkg::CAL_IDLE;
         end
      endcase
   end

   // Busy kept in its own flop so the outputs need no decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_state_ff <= clk_ctrl_pkg::CAL_IDLE;
         cal_busy_ff  <= 1'b0;
      end else begin
         cal_state_ff <= nxt_cal_state;
         cal_busy_ff  <= (nxt_cal_state == clk_ctrl_pkg::CAL_RUN);
      end
   end

   // Band and amplitude search modelled as a fixed duration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_cnt_ff <= 17'h00000;
      end else if ((cal_state_ff == clk_ctrl_pkg::CAL_IDLE)
                   & cal_start_ok) begin
         cal_cnt_ff <= CAL_LOAD;
      end else if (cal_cnt_ff != 17'h00000) begin
         cal_cnt_ff <= cal_cnt_ff - 17'h00001;
      end
   end

   // Loop state, active reference and free-run select halt while calibrating
   assign halted = (cal_state_ff == clk_ctrl_pkg::CAL_RUN);

   // Soft reset and sleep levels; full sleep implies every block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_ff <= 1'b0;
         sleep_ff      <= 6'h00;
      end else begin
         core_reset_ff <= pwr_ff[`PWR_SOFT_RST];
         sleep_ff[5]   <= pwr_ff[`PWR_SYS_SLEEP]
                          | pwr_ff[`PWR_FULL_SLEEP];
         sleep_ff[4]   <= pwr_ff[`PWR_REF_SLEEP]
                          | pwr_ff[`PWR_FULL_SLEEP];
         sleep_ff[3]   <= pwr_ff[`PWR_PHASE_SLEEP]
                          | pwr_ff[`PWR_FULL_SLEEP];
         sleep_ff[2]   <= pwr_ff[`PWR_DAC_SLEEP]
                          | pwr_ff[`PWR_FULL_SLEEP];
         sleep_ff[1]   <= pwr_ff[`PWR_DIST_SLEEP]
                          | pwr_ff[`PWR_FULL_SLEEP];
         sleep_ff[0]   <= pwr_ff[`PWR_FULL_SLEEP];
      end
   end

   // Policy and preferred reference
   assign policy     = clk_ctrl_pkg::policy_type'(
                          loop_ff[`LOOP_POL_HI:`LOOP_POL_LO]);
   assign pref       = loop_ff[`LOOP_PREF_HI:`LOOP_PREF_LO];
   assign pref_valid = ref_valid[pref];

   // Reference switching decision; free run checked first
   always_comb begin
      nxt_loop_state = clk_ctrl_pkg::LOOP_TRACK;
      nxt_active_ref = active_ref_ff;
      if (loop_ff[`LOOP_FREE]) begin
         nxt_loop_state = clk_ctrl_pkg::LOOP_FREE;
      end else if (loop_ff[`LOOP_HOLD]) begin
         nxt_loop_state = clk_ctrl_pkg::LOOP_HOLD;
      end else begin
         case (policy)
            clk_ctrl_pkg::POL_AUTO: begin
               if (auto_ref_found) begin
                  nxt_active_ref = auto_ref_sel;
               end else begin
                  nxt_loop_state = clk_ctrl_pkg::LOOP_HOLD;
               end
            end
            clk_ctrl_pkg::POL_FALLBACK: begin
               if (pref_valid) begin
                  nxt_active_ref = pref;
               end else if (auto_ref_found) begin
                  nxt_active_ref = auto_ref_sel;
               end else begin
                  nxt_loop_state = clk_ctrl_pkg::LOOP_HOLD;
               end
            end
            clk_ctrl_pkg::POL_HOLDOVER: begin
               if (pref_valid) begin
                  nxt_active_ref = pref;
               end else begin
                  nxt_loop_state = clk_ctrl_pkg::LOOP_HOLD;
               end
            end
            clk_ctrl_pkg::POL_MANUAL: begin
               nxt_active_ref = pref;
            end
            default: begin
               nxt_loop_state = clk_ctrl_pkg::LOOP_HOLD;
            end
         endcase
      end
   end

   // Soft reset returns loop outputs to defaults; calibration freezes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_state_ff  <= 2'h0;
         active_ref_ff  <= 2'h0;
         freerun_sel_ff <= 1'b0;
      end else if (pwr_ff[`PWR_SOFT_RST]) begin
         loop_state_ff  <= 2'h0;
         active_ref_ff  <= 2'h0;
         freerun_sel_ff <= 1'b0;
      end else if (!halted) begin
         loop_state_ff  <= nxt_loop_state;
         active_ref_ff  <= nxt_active_ref;
         freerun_sel_ff <= loop_ff[`LOOP_FREE];
      end
   end

   // Distribution stall and resync pulse on the falling sync bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_prev_ff   <= 1'b0;
         dist_stall_ff  <= 1'b0;
         dist_resync_ff <= 1'b0;
      end else begin
         sync_prev_ff   <= cal_ff[`CAL_SYNC];
         dist_stall_ff  <= cal_ff[`CAL_SYNC];
         dist_resync_ff <= sync_prev_ff & ~cal_ff[`CAL_SYNC];
      end
   end

   // The upper profile page folds onto the lower page, same offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prof_map_ff <= 12'h000;
      end else if (prof_addr[11:8] == `PROF_HI_PAGE) begin
         prof_map_ff <= {`PROF_LO_PAGE, prof_addr[7:0]};
      end else begin
         prof_map_ff <= prof_addr;
      end
   end

   // Outputs straight from flip-flops
   assign prdata               = prdata_ff;
   assign pready               = pready_ff;
   assign pslverr              = pslverr_ff;
   assign prof_map_addr        = prof_map_ff;
   assign core_reset_hold      = core_reset_ff;
   assign system_clock_sleep   = sleep_ff[5];
   assign reference_sleep      = sleep_ff[4];
   assign phase_detector_sleep = sleep_ff[3];
   assign dac_sleep            = sleep_ff[2];
   assign distribution_sleep   = sleep_ff[1];
   assign full_sleep           = sleep_ff[0];
   assign loop_state           = loop_state_ff;
   assign active_ref           = active_ref_ff;
   assign freerun_word_sel     = freerun_sel_ff;
   assign dist_stall           = dist_stall_ff;
   assign dist_resync          = dist_resync_ff;
   assign cal_busy             = cal_busy_ff;
   assign system_clock_stall   = cal_busy_ff;

endmodule

/* clk_ctrl_regs_asserts.sv */
// Concurrent checks on the ports of the control bank
`timescale 1ns/10ps
`include "clk_ctrl_defs.svh"

module clk_ctrl_regs_checker #(
   parameter int unsigned CAL_CYCLES = `CAL_TIME_US * `CLK_FREQ_MHZ
) (
   input wire logic        pclk,                 // Clock
   input wire logic        presetn,              // Reset, low
   input wire logic        psel,                 // Select
   input wire logic        penable,              // Enable
   input wire logic        pwrite,               // Direction
   input wire logic [13:0] paddr,                // Address
   input wire logic [31:0] prdata,               // Read data
   input wire logic        pready,               // Ready
   input wire logic        pslverr,              // Error
   input wire logic        sys_pll_enabled,      // PLL in use
   input wire logic [11:0] prof_addr,            // Profile address
   input wire logic [11:0] prof_map_addr,        // Mirrored address
   input wire logic        core_reset_hold,      // Soft reset
   input wire logic        system_clock_sleep,   // Input clock sleep
   input wire logic        reference_sleep,      // Receiver sleep
   input wire logic        phase_detector_sleep, // Converter sleep
   input wire logic        dac_sleep,            // DAC sleep
   input wire logic        distribution_sleep,   // Output sleep
   input wire logic        full_sleep,           // Device sleep
   input wire logic [1:0]  loop_state,           // Loop state
   input wire logic [1:0]  active_ref,           // Active reference
   input wire logic        freerun_word_sel,     // Free-run word
   input wire logic        dist_stall,           // Output stalled
   input wire logic        dist_resync,          // Resync pulse
   input wire logic        cal_busy,             // Calibrating
   input wire logic        system_clock_stall    // Clock stalled
);
   logic [15:0] busy_cnt_ff;  // Busy cycles of the current run

   // Wide enough for the full-length run, not only the short sim one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt_ff <= 16'h0000;
      end else begin
         busy_cnt_ff <= cal_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // One wait state, then a single-cycle answer inside an access
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_unmapped: assert property (pready && !(paddr inside
      {`ADDR_PWR, `ADDR_LOOP, `ADDR_CAL, `ADDR_STAT}) |-> pslverr)
      else $error("unmapped access not refused");
   a_err_rdata: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h00000000) else $error("refused read not zero");
   a_mirror_page: assert property (prof_addr[11:8] == 4'h7
      |=> prof_map_addr[11:8] == 4'h6) else $error("page not mirrored");
   a_mirror_pass: assert property (prof_addr[11:8] != 4'h7
      |=> prof_map_addr == $past(prof_addr)) else $error("address moved");
   a_full_sleep: assert property (full_sleep |-> system_clock_sleep &&
      reference_sleep && phase_detector_sleep && dac_sleep &&
      distribution_sleep) else $error("full sleep incomplete");
   a_free_wins: assert property (freerun_word_sel
      |-> loop_state == 2'b10) else $error("free run not obeyed");
   a_hold_ref: assert property (loop_state == 2'b01 &&
      $past(loop_state) == 2'b01 |-> $stable(active_ref))
      else $error("reference moved in holdover");
   a_soft_reset: assert property (core_reset_hold
      |-> loop_state == 2'b00 && active_ref == 2'b00 && !freerun_word_sel)
      else $error("soft reset not applied");
   a_resync_after: assert property ($fell(dist_stall)
      |-> ##[0:2] dist_resync) else $error("no resync after stall");
   a_resync_pulse: assert property (dist_resync |=> !dist_resync)
      else $error("resync longer than one cycle");
   a_stall_cal: assert property (system_clock_stall == cal_busy)
      else $error("clock stall differs from calibration");
   a_cal_length: assert property ($fell(cal_busy)
      |-> busy_cnt_ff == CAL_CYCLES) else $error("calibration length");
   a_cal_enable: assert property ($rose(cal_busy)
      |-> $past(sys_pll_enabled)) else $error("calibration without PLL");

   // Main scenarios reached
   c_cal: cover property ($rose(cal_busy));
   c_resync: cover property (dist_resync);
   c_refused: cover property (pready && pslverr);
   c_free: cover property (freerun_word_sel);
endmodule

/* clock_sync_operational_controls_tb.sv */
// Self-checking bench for the operational control bank
`timescale 1ns/10ps
`include "clk_ctrl_defs.svh"

module clock_sync_operational_controls_tb;
   localparam int unsigned CAL_N = 8;  // Short calibration for sim
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  ref_valid;
   logic [1:0]  auto_ref_sel, loop_state, active_ref;
   logic [11:0] prof_addr, prof_map_addr;
   logic        auto_ref_found, sys_pll_enabled, core_reset_hold, rerr;
   logic        system_clock_sleep, reference_sleep, phase_detector_sleep;
   logic        dac_sleep, distribution_sleep, full_sleep, freerun_word_sel;
   logic        dist_stall, dist_resync, cal_busy, system_clock_stall;
   int          fails, num_checks;

   clk_ctrl_regs #(.CAL_CYCLES(CAL_N)) clk_ctrl_regs_inst (.*);

   // Free-running 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Request stays put until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [13:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
   endtask

   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(rdat, {24'h000000, e}, "read");
      chk(32'(rerr), 32'h0, "pslverr");
   endtask

   // Outputs trail the register by up to two cycles
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask

   task automatic t_power();
      logic [7:0] b;
      wr(`ADDR_LOOP, 8'h1B);
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         wr(`ADDR_PWR, b);
         settle();
         chk(32'({core_reset_hold, system_clock_sleep, reference_sleep,
             phase_detector_sleep, dac_sleep, distribution_sleep,
             full_sleep}), 32'({b[7], b[5:1] | {5{b[0]}}, b[0]}),
             "sleep");
         rd(`ADDR_PWR, b & 8'hBF);
         if (i == 7) begin
            chk(32'({loop_state, active_ref}), 32'h0, "soft");
            rd(`ADDR_LOOP, 8'h1B);
         end
      end
      wr(`ADDR_PWR, 8'h00);
      settle();
      chk(32'(active_ref), 32'h3, "manual");
   endtask

   // Loop write with reference status, then state and reference
   task automatic lp(input logic [7:0] w, input logic [3:0] v,
                     input logic f, input logic [1:0] s, st, ar);
      @(posedge pclk);
      ref_valid      <= v;
      auto_ref_found <= f;
      auto_ref_sel   <= s;
      wr(`ADDR_LOOP, w);
      settle();
      chk(32'({freerun_word_sel, loop_state, active_ref}),
          32'({w[5], st, ar}), "loop");
   endtask

   task automatic t_loop();
      lp(8'h03, 4'h0, 1'b1, 2'd2, 2'd0, 2'd2);
      lp(8'h00, 4'hF, 1'b0, 2'd1, 2'd1, 2'd2);
      lp(8'h09, 4'h2, 1'b1, 2'd2, 2'd0, 2'd1);
      lp(8'h0B, 4'h7, 1'b1, 2'd2, 2'd0, 2'd2);
      lp(8'h10, 4'h1, 1'b1, 2'd3, 2'd0, 2'd0);
      lp(8'h12, 4'hB, 1'b1, 2'd3, 2'd1, 2'd0);
      lp(8'h1A, 4'h0, 1'b0, 2'd0, 2'd0, 2'd2);
      lp(8'h5A, 4'hF, 1'b1, 2'd1, 2'd1, 2'd2);
      lp(8'h7A, 4'hF, 1'b1, 2'd1, 2'd2, 2'd2);
      lp(8'h20, 4'hF, 1'b1, 2'd1, 2'd2, 2'd2);
      lp(8'h00, 4'hF, 1'b1, 2'd1, 2'd0, 2'd1);
   endtask

   task automatic t_sync();
      int n = 0;
      wr(`ADDR_CAL, 8'h02);
      settle();
      chk(32'({dist_stall, dist_resync}), 32'h2, "stall");
      rd(`ADDR_STAT, 8'h11);
      wr(`ADDR_CAL, 8'h00);
      repeat (6) begin
         @(posedge pclk);
         #1;
         if (dist_resync === 1'b1) n++;
      end
      chk(32'(n), 32'h1, "resync");
      chk(32'(dist_stall), 32'h0, "unstall");
   endtask

   task automatic busy_count(input int k, output int n);
      n = 0;
      repeat (k) begin
         @(posedge pclk);
         #1;
         if (cal_busy === 1'b1) n++;
      end
   endtask

   task automatic t_cal();
      int n;
      wr(`ADDR_CAL, 8'h01);
      busy_count(20, n);
      chk(32'(n), CAL_N, "cal length");
      rd(`ADDR_CAL, 8'h00);
      sys_pll_enabled <= 1'b0;
      wr(`ADDR_CAL, 8'h01);
      busy_count(8, n);
      chk(32'(n), 32'h0, "cal refused");
      rd(`ADDR_CAL, 8'h00);
      sys_pll_enabled <= 1'b1;
   endtask

   task automatic t_prof();
      logic [11:0] a [6] = '{12'h700, 12'h731, 12'h7B2, 12'h7FF,
                             12'h6B2, 12'hA01};
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         prof_addr <= a[i];
         settle();
         chk(32'(prof_map_addr), 32'({a[i][11:8] == 4'h7 ? 4'h6 :
             a[i][11:8], a[i][7:0]}), "mirror");
      end
   endtask

   // Refusals, then a second reset in mid-run
   task automatic t_err_reset();
      apb(1'b0, 14'h2810, 32'h00000000);
      chk({rdat[30:0], rerr}, 32'h1, "unmapped");
      apb(1'b1, `ADDR_STAT, 32'h000000FF);
      chk(32'(rerr), 32'h1, "status write");
      wr(`ADDR_PWR, 8'h3F);
      wr(`ADDR_LOOP, 8'h7B);
      wr(`ADDR_CAL, 8'h02);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk(32'({full_sleep, dist_stall, loop_state}), 32'h0, "outs");
      rd(`ADDR_PWR, 8'h00);
      rd(`ADDR_LOOP, 8'h00);
      rd(`ADDR_CAL, 8'h00);
   endtask

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, auto_ref_found} = 5'b00000;
      {paddr, pwdata, ref_valid, auto_ref_sel} = '0;
      prof_addr = 12'h000;
      sys_pll_enabled = 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ADDR_PWR, 8'h00);
      rd(`ADDR_LOOP, 8'h00);
      rd(`ADDR_CAL, 8'h00);
      t_power();
      t_loop();
      t_sync();
      t_cal();
      t_prof();
      t_err_reset();
      tally_and_finish();
   end

   // Run needs well under 2000 cycles
   initial begin
      #500000;
      fails++;
      $display("Error %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule

bind clk_ctrl_regs clk_ctrl_regs_checker #(.CAL_CYCLES(CAL_CYCLES))
   clk_ctrl_regs_checker_inst (.*);
